//--- asp_dev_model.sv
`timescale 1ns/10ps

module asp_dev_model #(
  parameter int WAKE_NS = 2500,
  parameter int GAP_NS = 60,
  parameter int CONV_NS = 3000,
  parameter int HALF_MIN_NS = 230,
  parameter int HALF_MAX_NS = 5000
) (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic chan,
  input wire logic [9:0] code,
  input wire logic [1:0] subs,
  input wire logic hang,
  output logic dout,
  output int viol_cnt
);
  logic int_mode = 1'b0;
  logic started = 1'b0;
  logic ready = 1'b0;
  logic [15:0] frame = 16'h0000;
  int idx = 0;
  realtime t_sel = -1.0e6;
  realtime t_desel = -1.0e6;
  realtime t_edge = -1.0;

  initial dout = 1'b0;
  initial viol_cnt = 0;

  // ----------------------------------------
  // Select fall: wake, pick mode, load frame
  // ----------------------------------------
  // Deselect gap watched
  always @(negedge cs_n)
  begin
    if ($realtime - t_desel < GAP_NS)
      viol_cnt++;
    t_sel = $realtime;
    t_edge = -1.0;
    int_mode = sclk;
    frame = {3'b111, chan, code, subs};
    idx = 0;
    started = 1'b0;
    ready = !int_mode;
    dout = !int_mode;
  end

  always @(sclk)
  begin
    if (cs_n === 1'b0)
    begin
      if ($realtime - t_sel < WAKE_NS)
        viol_cnt++;
      if (!int_mode && t_edge >= 0.0 &&
          ($realtime - t_edge < HALF_MIN_NS || $realtime - t_edge > HALF_MAX_NS))
        viol_cnt++;
      t_edge = $realtime;
    end
  end

  always @(negedge sclk)
  begin
    if (cs_n === 1'b0)
    begin
      if (int_mode && !started)
        started = 1'b1;
      else if (ready)
      begin
        idx++;
        dout = (idx < 16) ? frame[15 - idx] : 1'b0;
      end
    end
  end

  always @(posedge started)
  begin
    #(CONV_NS);
    if (started && !hang)
    begin
      ready = 1'b1;
      dout = 1'b1;
    end
  end

  // Released line shows the opposite level
  always @(posedge cs_n)
  begin
    t_desel = $realtime;
    started = 1'b0;
    ready = 1'b0;
    dout = ~dout;
  end
endmodule // asp_dev_model

//--- asp_host.sv
// Contract
// - Host captures data on rising edges
// - External mode: select falls with clock low
// - Wait wake delay before any clock edge
// - Sixteen clock cycles per conversion
// - Deselect at or after sixteenth falling edge
// - Keep deselected for least gap
// - Early deselect aborts, same gap follows
// - External clock within lower/upper rate
// - Whole frame or two bytes
// - Clock idles low, capture on rise
`timescale 1ns/10ps

module asp_host #(
  parameter int HALF_CYC = 32,
  parameter int BYTE_GAP_CYC = 32,
  parameter int CONV_TIMEOUT_CYC = 2000
) (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic START,
  input wire logic MODE_INT,
  input wire logic BYTE_MODE,
  input wire logic ABORT,
  input wire logic DOUT,
  output logic CS_N,
  output logic SCLK,
  output logic BUSY,
  output logic DONE,
  output logic ABORTED,
  output logic FRAME_OK,
  output logic EOC_FLAG,
  output logic CHANNEL_TAG,
  output logic [asp_pkg::RES_W-1:0] RESULT,
  output logic [asp_pkg::SUB_W-1:0] SUB_BITS
);
  import asp_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  asp_state_e state_ff;
  logic [CNT_W-1:0] timer_ff;
  logic [CNT_W-1:0] half_ff;
  logic [BIT_W-1:0] bit_cnt_ff;
  logic [FRAME_W-1:0] shift_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic mode_int_ff;
  logic byte_mode_ff;
  logic done_ff;
  logic aborted_ff;
  logic dout_s;
  logic half_end;
  logic active;
  logic [CNT_W-1:0] since_cs_ff;
  logic [CNT_W-1:0] hold_ff;
  logic sclk_prev_ff;

  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYC - 1);
  localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYC - 1);
  localparam logic [CNT_W-1:0] BYTE_GAP_LAST = CNT_W'(BYTE_GAP_CYC - 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  // ----------------------------------------
  // Data line synchroniser
  // ----------------------------------------
  asp_sync2 u_dout_sync (
    .clk_sys(CLK_SYS),
    .nrst(NRST),
    .async_in(DOUT),
    .sync_out(dout_s)
  );

  // Handshake and pin outputs
  // half period sets rate
  assign half_end = (half_ff == HALF_LAST);
  assign active = (state_ff != ASP_IDLE) && (state_ff != ASP_GAP);
  assign BUSY = (state_ff != ASP_IDLE);
  assign CS_N = cs_n_ff;
  assign SCLK = sclk_ff;
  assign DONE = done_ff;
  assign ABORTED = aborted_ff;

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  // Select, serial clock, timers and bit count
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      state_ff <= ASP_IDLE;
      timer_ff <= '0;
      half_ff <= '0;
      bit_cnt_ff <= '0;
      sclk_ff <= 1'h0;
      cs_n_ff <= 1'h1;
      mode_int_ff <= 1'h0;
      byte_mode_ff <= 1'h0;
      done_ff <= 1'h0;
      aborted_ff <= 1'h0;
    end
    else
    begin
      done_ff <= 1'h0;
      aborted_ff <= 1'h0;
      if (ABORT && active)
      begin
        cs_n_ff <= 1'h1;
        sclk_ff <= 1'h0;
        timer_ff <= GAP_LAST;
        aborted_ff <= 1'h1;
        state_ff <= ASP_GAP;
      end
      else
      begin
        case (state_ff)
          ASP_IDLE:
          begin
            sclk_ff <= 1'h0;
            cs_n_ff <= 1'h1;
            bit_cnt_ff <= '0;
            if (START)
            begin
              mode_int_ff <= MODE_INT;
              byte_mode_ff <= BYTE_MODE;
              sclk_ff <= MODE_INT;
              timer_ff <= HALF_LAST;
              state_ff <= ASP_SETUP;
            end
          end
          ASP_SETUP:
          begin
            if (timer_ff == '0)
            begin
              cs_n_ff <= 1'h0;
              timer_ff <= WAKE_LAST;
              state_ff <= ASP_WAKE;
            end
            else
              timer_ff <= timer_ff - 1'h1;
          end
          ASP_WAKE:
          begin
            if (timer_ff == '0)
            begin
              half_ff <= '0;
              if (mode_int_ff)
              begin
                sclk_ff <= 1'h0;
                timer_ff <= CONV_LAST;
                state_ff <= ASP_CONV;
              end
              else
                state_ff <= ASP_SHIFT;
            end
            else
              timer_ff <= timer_ff - 1'h1;
          end
          ASP_CONV:
          begin
            // wait for done flag on data line
            if (dout_s)
              state_ff <= ASP_SHIFT;
            else if (timer_ff == '0)
            begin
              cs_n_ff <= 1'h1;
              timer_ff <= GAP_LAST;
              aborted_ff <= 1'h1;
              state_ff <= ASP_GAP;
            end
            else
              timer_ff <= timer_ff - 1'h1;
          end
          ASP_SHIFT:
          begin
            if (!half_end)
              half_ff <= half_ff + 1'h1;
            else
            begin
              half_ff <= '0;
              if (!sclk_ff)
              begin
                sclk_ff <= 1'h1;
                bit_cnt_ff <= bit_cnt_ff + 1'h1;
              end
              else
              begin
                sclk_ff <= 1'h0;
                if (bit_cnt_ff == FRAME_BITS)
                begin
                  cs_n_ff <= 1'h1;
                  timer_ff <= GAP_LAST;
                  done_ff <= 1'h1;
                  state_ff <= ASP_GAP;
                end
                else if (byte_mode_ff && bit_cnt_ff == BYTE_BITS)
                begin
                  timer_ff <= BYTE_GAP_LAST;
                  state_ff <= ASP_PAUSE;
                end
              end
            end
          end
          ASP_PAUSE:
          begin
            if (timer_ff == '0)
            begin
              half_ff <= '0;
              state_ff <= ASP_SHIFT;
            end
            else
              timer_ff <= timer_ff - 1'h1;
          end
          ASP_GAP:
          begin
            cs_n_ff <= 1'h1;
            sclk_ff <= 1'h0;
            if (timer_ff == '0)
              state_ff <= ASP_IDLE;
            else
              timer_ff <= timer_ff - 1'h1;
          end
          default:
            state_ff <= ASP_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Frame capture and unpacking
  // ----------------------------------------
  // data settled since last fall, taken at the rise
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
      shift_ff <= '0;
    else if (state_ff == ASP_SHIFT && half_end && !sclk_ff && !ABORT)
      shift_ff <= {shift_ff[FRAME_W-2:0], dout_s};
  end

  // result fields unpacked after a complete frame
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      RESULT <= '0;
      SUB_BITS <= '0;
      CHANNEL_TAG <= 1'h0;
      EOC_FLAG <= 1'h0;
      FRAME_OK <= 1'h0;
    end
    else if (done_ff)
    begin
      RESULT <= shift_ff[POS_RES_MSB:POS_RES_LSB];
      SUB_BITS <= {shift_ff[POS_SUB_HI], shift_ff[POS_SUB_LO]};
      CHANNEL_TAG <= shift_ff[POS_TAG];
      // first bit is the done flag in internal mode
      EOC_FLAG <= shift_ff[POS_FIRST];
      FRAME_OK <= shift_ff[POS_FIRST] & shift_ff[POS_ONE_HI] & shift_ff[POS_ONE_LO];
    end
  end

  // ----------------------------------------
  // Assertion helpers
  // ----------------------------------------
  // Cycles since select fell and cycles the clock has held
  always_ff @(posedge CLK_SYS or negedge NRST)
  begin
    if (!NRST)
    begin
      since_cs_ff <= '0;
      hold_ff <= '0;
      sclk_prev_ff <= 1'h0;
    end
    else
    begin
      sclk_prev_ff <= sclk_ff;
      if (cs_n_ff)
        since_cs_ff <= '0;
      else if (since_cs_ff != CNT_MAX)
        since_cs_ff <= since_cs_ff + 1'h1;
      if (sclk_ff != sclk_prev_ff)
        hold_ff <= '0;
      else if (hold_ff != CNT_MAX)
        hold_ff <= hold_ff + 1'h1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ext_select_low: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $fell(cs_n_ff) && !mode_int_ff |-> !sclk_ff)
    else $error("select fell with clock high in external mode");

  a_int_select_high: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $fell(cs_n_ff) |-> sclk_ff == mode_int_ff)
    else $error("clock level at select fall does not match mode");

  a_wake_no_edge: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $changed(sclk_ff) && !cs_n_ff |-> since_cs_ff >= CNT_W'(WAKE_CYC))
    else $error("clock edge before wake delay elapsed");

  a_rise_capture: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $changed(bit_cnt_ff) && bit_cnt_ff != '0 |-> $rose(sclk_ff) && !cs_n_ff)
    else $error("bit counted without a rising clock edge");

  a_full_frame: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    done_ff |-> cs_n_ff && bit_cnt_ff == FRAME_BITS && !sclk_ff)
    else $error("frame ended without sixteen clock cycles");

  a_deselect_low: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $rose(cs_n_ff) |-> !sclk_ff &&
      ($past(sclk_ff) || $past(state_ff) != ASP_SHIFT || $past(ABORT)))
    else $error("select raised away from a falling edge");

  a_gap_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $rose(cs_n_ff) |-> cs_n_ff [*8])
    else $error("select low again before the gap");

  a_abort_gap: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    ABORT && active |=> cs_n_ff && aborted_ff && state_ff == ASP_GAP)
    else $error("abort did not deselect at once");

  a_clock_rate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    $rose(sclk_ff) && !cs_n_ff |-> hold_ff >= CNT_W'(HALF_MIN_CYC - 1))
    else $error("serial clock low phase too short");

  a_byte_pause: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    state_ff == ASP_PAUSE |-> !sclk_ff && !cs_n_ff && bit_cnt_ff == BYTE_BITS)
    else $error("byte pause outside the byte boundary");

  a_idle_low: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    state_ff == ASP_IDLE |-> !sclk_ff && cs_n_ff)
    else $error("clock not idle low while idle");

endmodule // asp_host

//--- asp_host_tb_top.sv
`timescale 1ns/10ps

module asp_host_tb_top;
  import asp_pkg::*;
  localparam int H = 32;
  localparam int BG = 32;
  localparam int LAT = 1 + H + WAKE_CYC + 32 * H;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic mode_int = 1'b0;
  logic byte_mode = 1'b0;
  logic abort_req = 1'b0;
  logic chan = 1'b0;
  logic [9:0] code = 10'h000;
  logic [1:0] subs = 2'h0;
  logic hang = 1'b0;
  logic dout, cs_n, sclk, busy, done, aborted, frame_ok, eoc_flag, channel_tag;
  logic [RES_W-1:0] result;
  logic [SUB_W-1:0] sub_bits;
  int viol_cnt;
  int miscompares = 0;
  int check_count = 0;

  // Free-running system clock
  always #4 clk_sys = ~clk_sys;

  asp_host #(.HALF_CYC(H), .BYTE_GAP_CYC(BG), .CONV_TIMEOUT_CYC(2000)) asp_host_i (
    .CLK_SYS(clk_sys), .NRST(nrst), .START(start), .MODE_INT(mode_int),
    .BYTE_MODE(byte_mode), .ABORT(abort_req), .DOUT(dout), .CS_N(cs_n), .SCLK(sclk),
    .BUSY(busy), .DONE(done), .ABORTED(aborted), .FRAME_OK(frame_ok), .EOC_FLAG(eoc_flag),
    .CHANNEL_TAG(channel_tag), .RESULT(result), .SUB_BITS(sub_bits));

  asp_dev_model asp_dev_model_i (
    .cs_n(cs_n), .sclk(sclk), .chan(chan), .code(code), .subs(subs), .hang(hang),
    .dout(dout), .viol_cnt(viol_cnt));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check_val(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Request one conversion and wait for its end under a bound
  task automatic run_conv(input logic mi, input logic bm, input logic ch,
                          input logic [9:0] cd, input logic [1:0] sb,
                          output int n, output logic ab);
    n = 0;
    @(posedge clk_sys);
    chan <= ch;
    code <= cd;
    subs <= sb;
    mode_int <= mi;
    byte_mode <= bm;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    while (n < 20000 && done !== 1'b1 && aborted !== 1'b1)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    ab = aborted;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 100)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check_val("busy", busy, 1'b0);
  endtask

  task automatic check_frame(input logic mi, input logic ch, input logic [9:0] cd,
                             input logic [1:0] sb, input logic ab);
    check_val("aborted", ab, 1'b0);
    check_val("eoc", eoc_flag, 1'b1);
    check_val("lead", frame_ok, 1'b1);
    check_val("tag", channel_tag, ch);
    check_val("result", result, cd);
    check_val("subs", sub_bits, sb);
    check_val("mode", asp_dev_model_i.int_mode, mi);
    check_val("select", cs_n, 1'b1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check_val("select", cs_n, 1'b1);
    check_val("clock", sclk, 1'b0);
    check_val("busy", busy, 1'b0);
  endtask

  task automatic t_ext_word();
    int n;
    logic ab;
    run_conv(1'b0, 1'b0, 1'b0, 10'h2a5, 2'h1, n, ab);
    check_val("latency", (n >= LAT - 1 && n <= LAT + 1), 1'b1);
    check_frame(1'b0, 1'b0, 10'h2a5, 2'h1, ab);
    wait_idle();
  endtask

  task automatic t_ext_bytes();
    int n;
    logic ab;
    run_conv(1'b0, 1'b1, 1'b1, 10'h35a, 2'h2, n, ab);
    check_val("latency", (n >= LAT + BG - 1 && n <= LAT + BG + 1), 1'b1);
    check_frame(1'b0, 1'b1, 10'h35a, 2'h2, ab);
    wait_idle();
  endtask

  task automatic t_int();
    int n;
    logic ab;
    run_conv(1'b1, 1'b0, 1'b1, 10'h3ff, 2'h3, n, ab);
    check_frame(1'b1, 1'b1, 10'h3ff, 2'h3, ab);
    wait_idle();
    run_conv(1'b1, 1'b1, 1'b0, 10'h001, 2'h0, n, ab);
    check_frame(1'b1, 1'b0, 10'h001, 2'h0, ab);
    wait_idle();
  endtask

  task automatic t_abort();
    int k;
    logic [9:0] prev;
    prev = result;
    @(posedge clk_sys);
    code <= 10'h155;
    mode_int <= 1'b0;
    byte_mode <= 1'b0;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    repeat (600) @(posedge clk_sys);
    abort_req <= 1'b1;
    @(posedge clk_sys);
    abort_req <= 1'b0;
    #1;
    k = 0;
    while (aborted !== 1'b1 && k < 4)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check_val("aborted", aborted, 1'b1);
    @(posedge clk_sys);
    #1;
    check_val("select", cs_n, 1'b1);
    check_val("clock", sclk, 1'b0);
    check_val("kept", result, prev);
    wait_idle();
  endtask

  task automatic t_timeout();
    int n;
    logic ab;
    hang <= 1'b1;
    run_conv(1'b1, 1'b0, 1'b1, 10'h0f0, 2'h1, n, ab);
    check_val("timeout", ab, 1'b1);
    hang <= 1'b0;
    wait_idle();
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    t_reset();
    t_ext_word();
    t_ext_bytes();
    t_int();
    t_abort();
    t_ext_word();
    t_timeout();
    check_val("host faults", viol_cnt[15:0], 16'h0000);
    print_verdict();
  end

  // Watchdog against a hang
  initial
  begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule // asp_host_tb_top

//--- asp_pkg.sv
package asp_pkg;

  // ----------------------------------------
  // Clock and link timing
  // ----------------------------------------
  localparam int CLK_KHZ = 125000;          // System clock rate
  localparam int WAKE_NS = 2500;            // Wake delay after select falls
  localparam int GAP_NS = 60;               // Least deselect time
  localparam int SCLK_MAX_KHZ = 2170;       // Fastest external serial clock
  localparam int SCLK_MIN_KHZ = 100;        // Slowest external serial clock
  localparam int WAKE_CYC = (WAKE_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int GAP_CYC = (GAP_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int HALF_MIN_CYC = (CLK_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int HALF_MAX_CYC = CLK_KHZ / (2 * SCLK_MIN_KHZ);

  // ----------------------------------------
  // Frame layout, first bit in the top position
  // ----------------------------------------
  localparam int CNT_W = 16;
  localparam int BIT_W = 5;
  localparam int FRAME_W = 16;
  localparam int RES_W = 10;
  localparam int SUB_W = 2;
  localparam logic [BIT_W-1:0] FRAME_BITS = 5'h10;
  localparam logic [BIT_W-1:0] BYTE_BITS = 5'h08;
  localparam int POS_FIRST = 15;            // Leading one or done flag
  localparam int POS_ONE_HI = 14;
  localparam int POS_ONE_LO = 13;
  localparam int POS_TAG = 12;              // channel_tag
  localparam int POS_RES_MSB = 11;          // result_msb
  localparam int POS_RES_LSB = 2;           // result_lsb
  localparam int POS_SUB_HI = 1;            // sub_lsb_high
  localparam int POS_SUB_LO = 0;            // sub_lsb_low

  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ASP_IDLE,
    ASP_SETUP,
    ASP_WAKE,
    ASP_CONV,
    ASP_SHIFT,
    ASP_PAUSE,
    ASP_GAP
  } asp_state_e;

endpackage

//--- asp_sync2.sv
`timescale 1ns/10ps

module asp_sync2 (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_ff <= 1'h0;
      sync_out <= 1'h0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // asp_sync2
